// *** mac_pkg.sv ***
package mac_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [11:0] IDX_COMMAND_CONTROL = 12'hfa4;
    localparam logic [11:0] IDX_OPERATION_FLAGS = 12'hfa5;
    localparam logic [11:0] IDX_MULTIPLIER_LOW = 12'hfa6;
    localparam logic [11:0] IDX_MULTIPLIER_HIGH = 12'hfa7;
    localparam logic [11:0] IDX_MULTIPLICAND_LOW = 12'hfa8;
    localparam logic [11:0] IDX_MULTIPLICAND_HIGH = 12'hfa9;
    localparam logic [11:0] IDX_RESULT_BYTE0 = 12'hfaa;
    localparam logic [11:0] IDX_RESULT_BYTE1 = 12'hfab;
    localparam logic [11:0] IDX_RESULT_BYTE2 = 12'hfac;
    localparam logic [11:0] IDX_RESULT_BYTE3 = 12'hfad;

    // command_control layout
    localparam int CMD_RESULT_CLEAR_BIT = 7;
    localparam int CMD_MODE_LSB = 1;
    localparam int CMD_ENABLE_BIT = 0;
    localparam logic [2:0] CMD_FIXED_ONES = 3'h7;
    localparam logic [7:0] CMD_RESET = 8'h70;

    // operation_flags layout
    localparam logic [2:0] FLAGS_FIXED_ONES = 3'h7;
    localparam logic [7:0] FLAGS_RESET = 8'he0;

    // arith_mode_field codes
    localparam logic [2:0] MODE_UMUL = 3'h0;
    localparam logic [2:0] MODE_UMAC = 3'h1;
    localparam logic [2:0] MODE_SMUL = 3'h2;
    localparam logic [2:0] MODE_SMAC = 3'h3;

    // calculation length in system clock cycles
    localparam logic [3:0] OPERATION_IN_PROGRESS_CYCLES = 4'h4;

    localparam logic [15:0] OPERAND_RESET = 16'h0000;
    localparam logic [31:0] RESULT_RESET = 32'h00000000;
endpackage : mac_pkg

// *** mac_unit.sv ***
// Notes on behaviour
// - command: clear bit 7, ones in 6..4, mode 3..1, enable 0, reset 0x70.
// - clear bit resets result, addend, status; operands kept; bit self-clears next cycle.
// - mode 000 umul, 001 umac, 010 smul, 011 smac; 1xx reserved.
// - a mode write alone disturbs no other register.
// - clear bit writes are ignored while a calculation runs.
// - command bits 6..4 always read 1, writes there ignored.
// - status: ones in 7..5, carry 4, zero 3, sign 2, overflow 1, busy 0; reset 0xe0.
// - carry is 1 when a multiply-accumulate carried out, else 0.
// - zero flag is 1 when the last calculation ended with an all-zero result.
// - sign flag is 1 when the result is negative.
// - overflow flag is inverted in accumulate modes: 0 means overflow, 1 means none.
// - busy reads 1 during a calculation, 0 when idle.
// - result flags update at calculation end; status reads change nothing.
// - an addend write leaves zero and sign flags alone.
// - plain multiply modes read carry and overflow as 0.
// - signed modes treat operand bit 15 as two's-complement sign.
// - calculation starts on multiplicand high write following a low write.
// - a high write without a prior low write is dropped.
// - 32-bit result, overwritten by addend writes, reset zero, bit 31 sign in signed modes.
// - addend shares result addresses; writing it also changes the result unless a run ends in that cycle.
// - enable bit 1 turns the unit on until software clears it.
// - accumulate modes store product plus addend as 32 bits.
// - operand and addend writes are accepted only while enabled.
`timescale 1ns/1ps
`default_nettype none
module mac_unit (
    input wire logic clk, // system clock, 100 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [13:0] address, // avalon byte address
    input wire logic read, // avalon read request
    input wire logic write, // avalon write request
    input wire logic [3:0] byteenable, // avalon byte lanes
    input wire logic [31:0] writedata, // avalon write data
    output logic [31:0] readdata, // avalon read data, registered
    output logic waitrequest // avalon stall, registered
);
    import mac_pkg::*;

    // bus decode nets
    logic [11:0] idx;
    logic wr_go;
    logic byte_wr;
    logic [7:0] wbyte;
    logic command_wr;
    logic clr_go;
    logic start;
    logic finish;
    logic addend_wr;
    logic [1:0] addend_lane;

    // command and status fields
    logic result_clear_bit;
    logic [2:0] arith_mode_field;
    logic unit_enable_bit;
    logic carry_flag;
    logic zero_flag;
    logic sign_flag;
    logic overflow_flag;
    logic operation_in_progress;
    logic [3:0] operation_in_progress_cnt;

    // software-visible operand and result storage
    logic [15:0] multiplier_operand;
    logic [15:0] multiplicand_operand;
    logic low_pending;
    logic [31:0] product_result;
    logic [31:0] accumulate_addend;

    // operands frozen for the running calculation
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic [2:0] op_mode;

    // arithmetic and read path
    logic signed [16:0] sx_a;
    logic signed [16:0] sx_b;
    logic signed [33:0] prod_wide;
    logic [31:0] prod;
    logic [32:0] sum;
    logic acc_mode;
    logic ovf_hit;
    logic [31:0] next_result;
    logic [7:0] next_readdata;

    // bus decode; a write lands on the edge where waitrequest is sampled low
    assign idx = address[13:2];
    assign wr_go = write & ~waitrequest;
    assign byte_wr = wr_go & byteenable[0];
    assign wbyte = writedata[7:0];
    assign command_wr = byte_wr & (idx == IDX_COMMAND_CONTROL);

    // a clear during a run is simply lost, never queued
    assign clr_go = command_wr & wbyte[CMD_RESULT_CLEAR_BIT] & ~operation_in_progress;

    // start needs an armed low byte and an enabled unit
    assign start = byte_wr & unit_enable_bit & low_pending
        & (idx == IDX_MULTIPLICAND_HIGH);

    // run ends when the counter has run down
    assign finish = operation_in_progress & (operation_in_progress_cnt == 4'h0);

    // addend bytes share the result indices
    assign addend_wr = byte_wr & unit_enable_bit & (idx >= IDX_RESULT_BYTE0)
        & (idx <= IDX_RESULT_BYTE3);
    assign addend_lane = idx[1:0] - IDX_RESULT_BYTE0[1:0];

    // one wait cycle on every access keeps readdata a plain flop
    // costs a cycle per access but leaves no combinational path to the bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~((read | write) & waitrequest);
        end
    end

    // read mux; status reads have no side effects
    // unmapped indices read as zero
    always_comb begin
        next_readdata = 8'h00;
        case (idx)
            IDX_COMMAND_CONTROL: begin
                next_readdata = {result_clear_bit, CMD_FIXED_ONES, arith_mode_field,
                    unit_enable_bit};
            end
            IDX_OPERATION_FLAGS: begin
                next_readdata = {FLAGS_FIXED_ONES, carry_flag, zero_flag, sign_flag,
                    overflow_flag, operation_in_progress};
            end
            IDX_MULTIPLIER_LOW: next_readdata = multiplier_operand[7:0];
            IDX_MULTIPLIER_HIGH: next_readdata = multiplier_operand[15:8];
            IDX_MULTIPLICAND_LOW: next_readdata = multiplicand_operand[7:0];
            IDX_MULTIPLICAND_HIGH: next_readdata = multiplicand_operand[15:8];
            IDX_RESULT_BYTE0: next_readdata = product_result[7:0];
            IDX_RESULT_BYTE1: next_readdata = product_result[15:8];
            IDX_RESULT_BYTE2: next_readdata = product_result[23:16];
            IDX_RESULT_BYTE3: next_readdata = product_result[31:24];
            default: next_readdata = 8'h00;
        endcase
    end

    // read data captured as waitrequest drops, held until the next read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readdata <= 32'h00000000;
        end else if (read & waitrequest) begin
            readdata <= {24'h000000, next_readdata};
        end
    end

    // mode field: any write just replaces the code, nothing else moves
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arith_mode_field <= CMD_RESET[CMD_MODE_LSB +: 3];
        end else if (command_wr) begin
            arith_mode_field <= wbyte[CMD_MODE_LSB +: 3];
        end
    end

    // enable bit: stays on until software writes it back to 0
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            unit_enable_bit <= CMD_RESET[CMD_ENABLE_BIT];
        end else if (command_wr) begin
            unit_enable_bit <= wbyte[CMD_ENABLE_BIT];
        end
    end

    // clear bit reads 1 for exactly one cycle after an accepted clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_clear_bit <= CMD_RESET[7];
        end else begin
            result_clear_bit <= clr_go;
        end
    end

    // multiplier bytes, enable-gated; cleared while disabled
    always_ff @(posedge clk) begin
        if (!rst_n || !unit_enable_bit) begin
            multiplier_operand <= OPERAND_RESET;
        end else if (byte_wr && idx == IDX_MULTIPLIER_LOW) begin
            multiplier_operand[7:0] <= wbyte;
        end else if (byte_wr && idx == IDX_MULTIPLIER_HIGH) begin
            multiplier_operand[15:8] <= wbyte;
        end
    end

    // multiplicand bytes: low byte lands whenever enabled, high byte only when armed
    always_ff @(posedge clk) begin
        if (!rst_n || !unit_enable_bit) begin
            multiplicand_operand <= OPERAND_RESET;
        end else if (byte_wr && idx == IDX_MULTIPLICAND_LOW) begin
            multiplicand_operand[7:0] <= wbyte;
        end else if (start) begin
            multiplicand_operand[15:8] <= wbyte;
        end
    end

    // arming flag: a low byte write arms, the start it enables disarms
    always_ff @(posedge clk) begin
        if (!rst_n || !unit_enable_bit) begin
            low_pending <= 1'b0;
        end else if (byte_wr && idx == IDX_MULTIPLICAND_LOW) begin
            low_pending <= 1'b1;
        end else if (start) begin
            low_pending <= 1'b0;
        end
    end

    // operands captured at start so next data may be loaded during a run
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_a <= OPERAND_RESET;
            op_b <= OPERAND_RESET;
        end else if (start) begin
            op_a <= multiplier_operand;
            op_b <= {wbyte, multiplicand_operand[7:0]};
        end
    end

    // mode latched with the operands; a later mode write cannot skew a run
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_mode <= MODE_UMUL;
        end else if (start) begin
            op_mode <= arith_mode_field;
        end
    end

    // busy flag; a new start restarts the run, disabling aborts it
    always_ff @(posedge clk) begin
        if (!rst_n || !unit_enable_bit) begin
            operation_in_progress <= 1'b0;
        end else if (start) begin
            operation_in_progress <= 1'b1;
        end else if (finish) begin
            operation_in_progress <= 1'b0;
        end
    end

    // cycle counter; reaching zero while busy ends the run
    always_ff @(posedge clk) begin
        if (!rst_n || !unit_enable_bit) begin
            operation_in_progress_cnt <= 4'h0;
        end else if (start) begin
            operation_in_progress_cnt <= OPERATION_IN_PROGRESS_CYCLES - 4'h1;
        end else if (operation_in_progress && !finish) begin
            operation_in_progress_cnt <= operation_in_progress_cnt - 4'h1;
        end
    end

    // arithmetic; reserved codes run as their low two bits
    assign acc_mode = op_mode[0];
    assign sx_a = {op_mode[1] & op_a[15], op_a};
    assign sx_b = {op_mode[1] & op_b[15], op_b};

    // one 17x17 signed product serves signed and unsigned operands alike
    assign prod_wide = sx_a * sx_b;
    assign prod = prod_wide[31:0];

    // accumulate adds the addend; a plain multiply adds nothing
    assign sum = {1'b0, prod} + (acc_mode ? {1'b0, accumulate_addend} : 33'h000000000);
    assign next_result = sum[31:0];

    // signed overflow from like-signed inputs, unsigned from the carry out
    assign ovf_hit = op_mode[1]
        ? ((prod[31] == accumulate_addend[31]) && (sum[31] != prod[31]))
        : sum[32];

    // one lane per result byte; an addend byte write lands in both copies unless a run ends in that cycle
    for (genvar lane = 0; lane < 4; lane++) begin : g_lane
        logic lane_wr;
        logic [7:0] res_byte;
        logic [7:0] add_byte;

        assign lane_wr = addend_wr & (addend_lane == 2'(lane));
        assign product_result[lane*8 +: 8] = res_byte;
        assign accumulate_addend[lane*8 +: 8] = add_byte;

        // result byte: cleared, computed, or overwritten by the addend byte
        always_ff @(posedge clk) begin
            if (!rst_n || !unit_enable_bit || clr_go) begin
                res_byte <= RESULT_RESET[lane*8 +: 8];
            end else if (finish) begin
                res_byte <= next_result[lane*8 +: 8];
            end else if (lane_wr) begin
                res_byte <= wbyte;
            end
        end

        // addend byte is write-only; it survives a run and feeds every accumulate
        always_ff @(posedge clk) begin
            if (!rst_n || !unit_enable_bit || clr_go) begin
                add_byte <= RESULT_RESET[lane*8 +: 8];
            end else if (lane_wr) begin
                add_byte <= wbyte;
            end
        end
    end

    // carry: only an accumulate can carry out of bit 31
    always_ff @(posedge clk) begin
        if (!rst_n || !unit_enable_bit || clr_go) begin
            carry_flag <= FLAGS_RESET[4];
        end else if (finish) begin
            carry_flag <= acc_mode & sum[32];
        end
    end

    // zero: moves only at run end or when cleared, disabled or reset, so addend writes cannot disturb it
    always_ff @(posedge clk) begin
        if (!rst_n || !unit_enable_bit || clr_go) begin
            zero_flag <= FLAGS_RESET[3];
        end else if (finish) begin
            zero_flag <= (next_result == RESULT_RESET);
        end
    end

    // sign: unsigned results are never reported negative
    always_ff @(posedge clk) begin
        if (!rst_n || !unit_enable_bit || clr_go) begin
            sign_flag <= FLAGS_RESET[2];
        end else if (finish) begin
            sign_flag <= op_mode[1] & next_result[31];
        end
    end

    // overflow reads inverted; plain multiplies show 0 rather than none
    always_ff @(posedge clk) begin
        if (!rst_n || !unit_enable_bit || clr_go) begin
            overflow_flag <= FLAGS_RESET[1];
        end else if (finish) begin
            overflow_flag <= acc_mode & ~ovf_hit;
        end
    end
endmodule : mac_unit
`default_nettype wire

// *** mac_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_sva
    import mac_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst_n, // sync reset
    input wire logic [13:0] address, // byte address
    input wire logic read, // read
    input wire logic write, // write
    input wire logic [3:0] byteenable, // lanes
    input wire logic [31:0] writedata, // write data
    input wire logic [31:0] readdata, // read data
    input wire logic waitrequest // stall
);
    logic [11:0] idx;
    logic acc_wr;
    logic en;
    logic armed;
    logic [3:0] left;
    // accepted byte write and its register
    assign idx = address[13:2];
    assign acc_wr = write && !waitrequest && byteenable[0];
    // shadow of the enable bit
    always_ff @(posedge clk) begin
        if (!rst_n) en <= 1'b0;
        else if (acc_wr && idx == IDX_COMMAND_CONTROL) en <= writedata[0];
    end
    // low byte must precede the high byte for a start
    always_ff @(posedge clk) begin
        if (!rst_n || !en) armed <= 1'b0;
        else if (acc_wr && idx == IDX_MULTIPLICAND_LOW) armed <= 1'b1;
        else if (acc_wr && idx == IDX_MULTIPLICAND_HIGH) armed <= 1'b0;
    end
    // cycles left in a run; disabling aborts it
    always_ff @(posedge clk) begin
        if (!rst_n || !en) left <= 4'h0;
        else if (acc_wr && idx == IDX_MULTIPLICAND_HIGH && armed) left <= OPERATION_IN_PROGRESS_CYCLES;
        else if (left != 4'h0) left <= left - 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("waitrequest not low for exactly one cycle");
    a_wait_rest: assert property (!(read || write) && waitrequest |=> waitrequest)
        else $error("waitrequest dropped with no request");
    a_cmd_ones: assert property (read && !waitrequest && idx == IDX_COMMAND_CONTROL
        |-> readdata[6:4] == CMD_FIXED_ONES) else $error("command bits 6..4 not ones");
    a_flag_ones: assert property (read && !waitrequest && idx == IDX_OPERATION_FLAGS
        |-> readdata[7:5] == FLAGS_FIXED_ONES) else $error("status bits 7..5 not ones");
    a_busy_track: assert property (read && waitrequest && idx == IDX_OPERATION_FLAGS
        |=> readdata[0] == ($past(left) != 4'h0)) else $error("busy flag wrong");
    a_zero_sign: assert property (read && !waitrequest && idx == IDX_OPERATION_FLAGS
        |-> !(readdata[3] && readdata[2])) else $error("zero and sign both set");
    a_byte_wide: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
        else $error("readdata upper bits not zero");
    a_hold_rdata: assert property (!(read && waitrequest) |=> $stable(readdata))
        else $error("readdata changed without a read");
    cover property (left == OPERATION_IN_PROGRESS_CYCLES);
    cover property (acc_wr && idx == IDX_RESULT_BYTE0);
    cover property (read && !waitrequest && idx == IDX_OPERATION_FLAGS && readdata[4]);
endmodule : mac_sva
bind mac_unit mac_sva mac_sva_i (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest));
`default_nettype wire

// *** mac_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_cpu_model (
    input wire logic clk, // clock
    output logic [13:0] address, // byte address
    output logic read, // read
    output logic write, // write
    output logic [3:0] byteenable, // lanes
    output logic [31:0] writedata, // write data
    input wire logic [31:0] readdata, // read data
    input wire logic waitrequest // stall
);
    // idle bus at time zero
    initial begin
        address = 14'h0;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'h0;
        writedata = 32'h0;
    end
    // one access; released address and data lines carry inverted junk, not stale values
    task automatic acc(input logic w, input logic [11:0] i, input logic [7:0] d,
            output logic [7:0] q);
        @(posedge clk);
        address <= {i, 2'($urandom)};
        writedata <= {24'($urandom), d};
        byteenable <= {3'($urandom), 1'b1};
        read <= !w;
        write <= w;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        address <= ~address;
        writedata <= ~writedata;
    endtask : acc
endmodule : mac_cpu_model
`default_nettype wire

// *** test_multiply_accumulate_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_multiply_accumulate_unit;
    import mac_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] address;
    logic read, write, waitrequest;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, r, exp_r;
    logic [7:0] q, exp_f;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
    mac_unit mac_unit_i (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest));
    mac_cpu_model mac_cpu_model_i (.clk(clk), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));
    always #5 clk = ~clk;
    // hang guard, far above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [11:0] i, input logic [7:0] d);
        mac_cpu_model_i.acc(1'b1, i, d, q);
    endtask : wr
    task automatic rd(input logic [11:0] i, output logic [7:0] d);
        mac_cpu_model_i.acc(1'b0, i, 8'h00, d);
    endtask : rd
    task automatic chk_rd(input string n, input logic [11:0] i, input logic [7:0] e);
        rd(i, q);
        `CHK(n, e, q)
    endtask : chk_rd
    task automatic rd_res(output logic [31:0] v);
        for (int k = 0; k < 4; k++) begin
            rd(12'(IDX_RESULT_BYTE0 + k), q);
            v[8 * k +: 8] = q;
        end
    endtask : rd_res
    // reference: flags byte then 32-bit result
    function automatic logic [39:0] model(input logic [2:0] m, input logic [15:0] a, b,
            input logic [31:0] c);
        logic [31:0] p;
        logic [32:0] s;
        logic ov;
        p = m[1] ? {{16{a[15]}}, a} * {{16{b[15]}}, b} : {16'h0, a} * {16'h0, b};
        s = {1'b0, c} + {1'b0, p};
        ov = m[1] ? (c[31] == p[31] && s[31] != c[31]) : s[32];
        if (!m[0]) return {4'he, p == 0, m[1] & p[31], 2'h0, p};
        return {3'h7, s[32], s[31:0] == 0, m[1] & s[31], !ov, 1'b0, s[31:0]};
    endfunction : model
    // one full calculation; clr tries a clear while busy
    task automatic run(input logic [2:0] m, input logic [15:0] a, b, input logic [31:0] c,
            input logic clr);
        wr(IDX_COMMAND_CONTROL, {4'h0, m, 1'b1});
        for (int k = 0; k < 4; k++) wr(12'(IDX_RESULT_BYTE0 + k), c[8 * k +: 8]);
        wr(IDX_MULTIPLIER_LOW, a[7:0]);
        wr(IDX_MULTIPLIER_HIGH, a[15:8]);
        wr(IDX_MULTIPLICAND_LOW, b[7:0]);
        wr(IDX_MULTIPLICAND_HIGH, b[15:8]);
        if (clr) wr(IDX_COMMAND_CONTROL, {4'h8, m, 1'b1});
        else rd(IDX_OPERATION_FLAGS, q);
        if (!clr) `CHK("busy", 1'b1, q[0])
        do rd(IDX_OPERATION_FLAGS, q); while (q[0] !== 1'b0);
        {exp_f, exp_r} = model(m, a, b, c);
        rd_res(r);
        `CHK("result", exp_r, r)
        rd(IDX_OPERATION_FLAGS, q);
        `CHK("flags", exp_f, q)
    endtask : run
    initial begin
        void'($urandom(32'h420736e2));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++) chk_rd("reset", 12'(IDX_COMMAND_CONTROL + i),
            i == 0 ? CMD_RESET : i == 1 ? FLAGS_RESET : 8'h00);
        // operands refused while disabled
        wr(IDX_MULTIPLIER_LOW, 8'h5a);
        chk_rd("mpl off", IDX_MULTIPLIER_LOW, 8'h00);
        wr(IDX_COMMAND_CONTROL, 8'h01);
        chk_rd("cmd", IDX_COMMAND_CONTROL, 8'h71);
        for (int m = 0; m < 4; m++)
            for (int t = 0; t < 6; t++) run(3'(m), t == 0 ? 16'h0 : 16'($urandom),
                t == 1 ? 16'hffff : 16'($urandom), $urandom, 1'b0);
        // lone high byte is dropped and starts nothing
        rd(IDX_MULTIPLICAND_HIGH, q);
        wr(IDX_MULTIPLICAND_HIGH, ~q);
        chk_rd("mcd hi", IDX_MULTIPLICAND_HIGH, q);
        chk_rd("idle flags", IDX_OPERATION_FLAGS, exp_f);
        wr(IDX_COMMAND_CONTROL, 8'h07);
        chk_rd("mode flags", IDX_OPERATION_FLAGS, exp_f);
        chk_rd("mode res", IDX_RESULT_BYTE3, exp_r[31:24]);
        wr(IDX_RESULT_BYTE0, 8'ha5);
        chk_rd("res0", IDX_RESULT_BYTE0, 8'ha5);
        chk_rd("add flags", IDX_OPERATION_FLAGS, exp_f);
        run(3'h3, 16'h8000, 16'h7fff, 32'h1, 1'b1);
        // clear when idle keeps operands and mode
        wr(IDX_COMMAND_CONTROL, 8'h87);
        chk_rd("cmd clr", IDX_COMMAND_CONTROL, 8'h77);
        rd_res(r);
        `CHK("cleared", 32'h0, r)
        chk_rd("clr flags", IDX_OPERATION_FLAGS, FLAGS_RESET);
        chk_rd("mpl kept", IDX_MULTIPLIER_HIGH, 8'h80);
        wr(IDX_COMMAND_CONTROL, 8'h06);
        chk_rd("mpl dis", IDX_MULTIPLIER_HIGH, 8'h00);
        chk_rd("cmd dis", IDX_COMMAND_CONTROL, 8'h76);
        end_of_test();
    end
endmodule : test_multiply_accumulate_unit
`default_nettype wire
